// >>> design/ksc_pkg.sv
`default_nettype none
package ksc_pkg;
    localparam logic [2:0] SEL_CODE = 3'h6;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_ID = 4'h3;
    localparam logic [3:0] REG_CLK_DATA = 4'h9;
    localparam logic [3:0] REG_KEYCODE = 4'hA;
    localparam logic [3:0] REG_TONE = 4'hB;
    localparam logic [3:0] REG_ADDR = 4'hC;
    localparam logic [3:0] REG_NV_DATA = 4'hD;
    localparam logic [3:0] REG_LOOP = 4'hF;
    // Identification pattern; value is arbitrary.
    localparam logic [7:0] ID_VALUE = 8'h5A;
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_PFW_BIT = 1;
    localparam int STAT_BATT_BIT = 3;
    localparam int SRQ_BIT = 6;
    localparam logic [15:0] STAT_DRIVE_MASK = 16'h0FFF;
    localparam logic [7:0] TONE_OFF = 8'hFF;
    localparam logic [7:0] TONE_RESET = 8'hFF;
    localparam logic [3:0] COLUMNS = 4'hF;
    localparam int CLK_HZ = 200_000_000;
    localparam int TONE_IN_HZ = 200_000;
    localparam int TONE_IN_DIV = 4;
    localparam int TONE_TICK_CYC = CLK_HZ / (TONE_IN_HZ / TONE_IN_DIV);
    localparam int LOCK_NS = 2_250_000;
    localparam int LOCK_CYC = LOCK_NS / (1_000_000_000 / CLK_HZ);
    localparam int SCAN_CYC = 16;
    localparam logic [4:0] REPEAT_RESET = 5'h00;
    localparam int LED_W = 2;
endpackage : ksc_pkg
`default_nettype wire

// >>> design/ksc_key_if.sv
`default_nettype none
interface ksc_key_if;
    logic valid;
    logic ready;
    logic [8:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : ksc_key_if
`default_nettype wire

// >>> design/ksc_key_buf.sv
`default_nettype none
// Two-entry buffer between the scanner and the holding register.
module ksc_key_buf #(
    parameter int W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    ksc_key_if.dst in_if,
    ksc_key_if.src out_if
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] cnt;
        logic wp;
        logic rp;
    } ksc_buf_t;
    ksc_buf_t s_q, s_d;
    logic push, pop;
    assign in_if.ready = s_q.cnt != 2'h2;
    assign out_if.valid = s_q.cnt != 2'h0;
    assign out_if.data = s_q.mem[s_q.rp];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_if.data[W-1:0];
            s_d.wp = ~s_q.wp;
        end
        if (pop) begin
            s_d.rp = ~s_q.rp;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.cnt != 2'h3) else $error("buffer count beyond two");
endmodule : ksc_key_buf
`default_nettype wire

// >>> design/ksc_scanner.sv
`default_nettype none
// Key matrix scanner: steps columns, reports new presses.
module ksc_scanner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] key_rows,
    input wire logic shift_key,
    input wire logic ctrl_key,
    output logic [3:0] key_column,
    ksc_key_if.src out_if
);
    typedef struct packed {
        logic [3:0] col;
        logic [4:0] dwell;
        logic [14:0][7:0] prev;
        logic pend;
        logic [8:0] code;
    } ksc_scan_t;
    ksc_scan_t s_q, s_d;
    logic [7:0] fresh;
    logic [2:0] row;
    function automatic logic [2:0] lowest(input logic [7:0] v);
        lowest = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                lowest = 3'(i);
            end
        end
    endfunction : lowest
    assign key_column = s_q.col;
    assign out_if.valid = s_q.pend;
    assign out_if.data = s_q.code;
    assign fresh = key_rows & ~s_q.prev[s_q.col];
    assign row = lowest(fresh);
    always_comb begin
        s_d = s_q;
        if (out_if.ready && s_q.pend) begin
            s_d.pend = 1'b0;
        end
        s_d.dwell = s_q.dwell + 5'h01;
        if (s_q.dwell == 5'(ksc_pkg::SCAN_CYC - 1) && !s_q.pend) begin
            s_d.dwell = 5'h00;
            if (fresh != 8'h00) begin // [R8]
                s_d.pend = 1'b1;
                s_d.code = {shift_key, ctrl_key, s_q.col, row};
                s_d.prev[s_q.col][row] = 1'b1;
            end else begin
                s_d.prev[s_q.col] = key_rows;
                s_d.col = (s_q.col == ksc_pkg::COLUMNS - 4'h1) ? 4'h0 :
                    s_q.col + 4'h1; // [R7]
            end
        end else if (s_q.dwell == 5'(ksc_pkg::SCAN_CYC - 1)) begin
            s_d.dwell = s_q.dwell;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    col_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.col < ksc_pkg::COLUMNS) else $error("column out of range"); // [R7]
endmodule : ksc_scanner
`default_nettype wire

// >>> design/ksc_interface.sv
`default_nettype none
// Summary of operation
// [R1] Register selects pick the addressed function.
// [R2] Respond only on matching select code.
// [R3] Register 3 read returns identification byte.
// [R4] Status: interrupt, power warning, battery fail.
// [R5] Keycode sets service request, bit 6; code puts it on status bit 0 and the status/flag lines instead.
// [R6] Two loopback latches readable via register 15.
// [R7] Scan fifteen columns of eight keys.
// [R8] New press loads keycode with modifiers.
// [R9] Keycode held from overwrite 2.25 ms.
// [R10] Host writes LEDs and repeat together.
// [R11] Repeat default 500/20 ms, 31 settings.
// [R12] Four-bit strapped language code presented.
// [R13] Tone divides 50 kHz by register 11.
// [R14] All-ones divide byte silences tone.
// [R15] Clock chip addressed via 12, data 9.
// [R16] Clock address advances after each access.
// [R17] Inverted store address via 12, data 13.
// [R18] Interface clear disables clock and store.
// [R19] Low battery at power-up sets status.
// [R20] Host reads battery status within seconds.
// [R21] Sixteen data and fourteen control lines.
// [R22] Drive bus only for owned registers.
// [R23] Drive select code status and flag.
// [R24] Ignore unowned writes, no drive otherwise.
// [R25] Keycode read clears request and pending.
module ksc_interface #(
    parameter int LOCK_CYCLES = ksc_pkg::LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] periph_addr,
    input wire logic [3:0] reg_sel,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic poll,
    input wire logic iface_clear,
    input wire logic power_fail_warn,
    input wire logic battery_low,
    input wire logic printer_status,
    input wire logic printer_flag,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [15:0] data_oe_n,
    output logic select_code_status_low,
    output logic select_code_flag_low,
    input wire logic [7:0] key_rows,
    input wire logic shift_key,
    input wire logic ctrl_key,
    output logic [3:0] key_column,
    input wire logic [3:0] language_strap,
    output logic [1:0] led,
    output logic [4:0] repeat_select,
    output logic tone_out,
    output logic clk_chip_enable,
    output logic clk_chip_we,
    output logic [3:0] clk_chip_addr,
    output logic [3:0] clk_chip_wdata,
    input wire logic [3:0] clk_chip_rdata,
    output logic nv_enable,
    output logic nv_we,
    output logic [10:0] nv_addr,
    output logic [7:0] nv_wdata,
    input wire logic [7:0] nv_rdata
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    typedef struct packed {
        logic [8:0] hold;
        logic srq;
        logic [LW-1:0] lock;
        logic [1:0] led;
        logic [4:0] rpt;
        logic [7:0] div;
        logic [7:0] cnt;
        logic [11:0] pre;
        logic tone;
        logic [3:0] caddr;
        logic [10:0] naddr;
        logic [15:0] loop;
        logic [15:0] dout;
        logic [15:0] oe_n;
        logic batt;
        logic batt_done;
        logic [3:0] lang;
        logic cwe;
        logic nwe;
        logic [7:0] wd;
    } ksc_state_t;
    ksc_state_t s_q, s_d;
    ksc_key_if scan_if ();
    ksc_key_if hold_if ();
    logic hit, rd, wr;
    ksc_scanner u_scan (
        .clk(clk),
        .rst_n(rst_n),
        .key_rows(key_rows),
        .shift_key(shift_key),
        .ctrl_key(ctrl_key),
        .key_column(key_column),
        .out_if(scan_if.src)
    );
    ksc_key_buf #(.W(9)) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_if(scan_if.dst),
        .out_if(hold_if.src)
    );
    function automatic logic owned(input logic [3:0] r);
        owned = r == ksc_pkg::REG_STATUS || r == ksc_pkg::REG_ID ||
            r == ksc_pkg::REG_CLK_DATA || r == ksc_pkg::REG_KEYCODE ||
            r == ksc_pkg::REG_TONE || r == ksc_pkg::REG_ADDR ||
            r == ksc_pkg::REG_NV_DATA || r == ksc_pkg::REG_LOOP;
    endfunction : owned
    assign hit = periph_addr == ksc_pkg::SEL_CODE; // [R2]
    assign rd = hit && rd_strobe;
    assign wr = hit && wr_strobe;
    // A new keycode only enters once the held one is read or the lockout ends.
    assign hold_if.ready = !s_q.srq || s_q.lock == '0; // [R9]
    always_comb begin
        s_d = s_q;
        s_d.cwe = 1'b0;
        s_d.nwe = 1'b0;
        s_d.oe_n = 16'hFFFF;
        s_d.dout = 16'h0000;
        if (s_q.lock != '0) begin
            s_d.lock = s_q.lock - LW'(1);
        end
        if (!s_q.batt_done) begin // [R19]
            s_d.batt = battery_low;
            s_d.batt_done = 1'b1;
            s_d.lang = language_strap; // [R12]
        end
        if (rd && owned(reg_sel)) begin // [R24]
            case (reg_sel) // [R1]
                ksc_pkg::REG_STATUS: begin
                    s_d.dout[ksc_pkg::STAT_IRQ_BIT] = s_q.srq; // [R4]
                    s_d.dout[ksc_pkg::STAT_PFW_BIT] = power_fail_warn;
                    s_d.dout[ksc_pkg::STAT_BATT_BIT] = s_q.batt;
                    s_d.dout[7:4] = s_q.lang;
                    s_d.oe_n = ~ksc_pkg::STAT_DRIVE_MASK; // [R22]
                end
                ksc_pkg::REG_ID: begin
                    s_d.dout[7:0] = ksc_pkg::ID_VALUE; // [R3]
                    s_d.oe_n = 16'hFF00;
                end
                ksc_pkg::REG_CLK_DATA: begin
                    if (!iface_clear) begin // [R18]
                        s_d.dout[3:0] = clk_chip_rdata;
                        s_d.oe_n = 16'hFF00;
                        // Post-increment: this access used the loaded address.
                        s_d.caddr = s_q.caddr + 4'h1; // [R16]
                    end
                end
                ksc_pkg::REG_KEYCODE: begin
                    s_d.dout[8:0] = s_q.hold;
                    s_d.oe_n = 16'h0000;
                    s_d.srq = 1'b0; // [R25]
                    s_d.lock = '0;
                end
                ksc_pkg::REG_NV_DATA: begin
                    if (!iface_clear) begin // [R18]
                        s_d.dout[7:0] = nv_rdata;
                        s_d.oe_n = 16'hFF00;
                    end
                end
                ksc_pkg::REG_LOOP: begin
                    s_d.dout = s_q.loop; // [R6]
                    s_d.oe_n = 16'h0000;
                end
                default: begin
                    s_d.oe_n = 16'hFFFF;
                end
            endcase
        end
        if (wr) begin
            case (reg_sel) // [R1]
                ksc_pkg::REG_CLK_DATA: begin
                    s_d.wd = {4'h0, data_in[3:0]};
                    s_d.cwe = !iface_clear; // [R18]
                    if (!iface_clear) begin
                        s_d.caddr = s_q.caddr + 4'h1; // [R16]
                    end
                end
                ksc_pkg::REG_KEYCODE: begin
                    s_d.led = data_in[1:0]; // [R10]
                    s_d.rpt = data_in[6:2]; // [R11]
                end
                ksc_pkg::REG_TONE: begin
                    s_d.div = data_in[7:0]; // [R13]
                end
                ksc_pkg::REG_ADDR: begin
                    s_d.caddr = data_in[3:0]; // [R15]
                    s_d.naddr = ~data_in[10:0]; // [R17]
                end
                ksc_pkg::REG_NV_DATA: begin
                    s_d.wd = data_in[7:0];
                    s_d.nwe = !iface_clear; // [R18]
                end
                ksc_pkg::REG_LOOP: begin
                    s_d.loop = data_in; // [R6]
                end
                default: begin
                    s_d.wd = s_q.wd; // [R24]
                end
            endcase
        end
        // Loading the holding register outranks the read clear. [R5]
        if (hold_if.valid && hold_if.ready) begin
            s_d.hold = hold_if.data; // [R8]
            s_d.srq = 1'b1; // [R5]
            s_d.lock = LW'(LOCK_CYCLES); // [R9]
        end
        s_d.pre = s_q.pre + 12'h001;
        if (s_q.pre == 12'(ksc_pkg::TONE_TICK_CYC - 1)) begin // [R13]
            s_d.pre = 12'h000;
            if (s_q.cnt == 8'h00) begin
                s_d.cnt = s_q.div;
                s_d.tone = ~s_q.tone;
            end else begin
                s_d.cnt = s_q.cnt - 8'h01;
            end
        end
        if (s_q.div == ksc_pkg::TONE_OFF) begin // [R14]
            s_d.tone = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.oe_n <= 16'hFFFF;
            s_q.div <= ksc_pkg::TONE_RESET;
            s_q.rpt <= ksc_pkg::REPEAT_RESET; // [R11]
        end else begin
            s_q <= s_d;
        end
    end
    // Data and enables are registered; the host samples a cycle after strobe.
    assign data_out = s_q.dout; // [R21]
    assign data_oe_n = s_q.oe_n;
    assign led = s_q.led;
    assign repeat_select = s_q.rpt;
    assign tone_out = s_q.tone;
    assign clk_chip_enable = !iface_clear; // [R18]
    assign nv_enable = !iface_clear;
    assign clk_chip_we = s_q.cwe && !iface_clear;
    assign nv_we = s_q.nwe && !iface_clear;
    // The write lands on the pre-increment address held a cycle earlier.
    assign clk_chip_addr = s_q.cwe ? s_q.caddr - 4'h1 : s_q.caddr;
    assign clk_chip_wdata = s_q.wd[3:0];
    assign nv_addr = s_q.naddr;
    assign nv_wdata = s_q.wd;
    // Status and flag lines are shared with the printer across the code.
    assign select_code_status_low = ~(s_q.srq | printer_status); // [R23]
    assign select_code_flag_low = ~((poll && hit && s_q.srq) |
        printer_flag); // [R5]
    srq_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
        hold_if.valid && hold_if.ready |=> s_q.srq) // [R5]
        else $error("service request not set on keycode load");
    read_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && reg_sel == ksc_pkg::REG_KEYCODE && !hold_if.valid
        |=> !s_q.srq) // [R25]
        else $error("keycode read did not clear request");
    lock_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.srq && s_q.lock != '0 |-> !hold_if.ready) // [R9]
        else $error("held keycode overwritable during lockout");
    id_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && reg_sel == ksc_pkg::REG_ID |=>
        data_out[7:0] == ksc_pkg::ID_VALUE && data_oe_n[7:0] == 8'h00) // [R3]
        else $error("identification byte wrong");
    foreign_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !hit |=> data_oe_n == 16'hFFFF) // [R2]
        else $error("drove bus for another select code");
    status_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && reg_sel == ksc_pkg::REG_STATUS |=>
        data_oe_n[15:12] == 4'hF && data_out[3] == $past(s_q.batt)) // [R22]
        else $error("status drive or battery bit wrong");
    tone_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.div == ksc_pkg::TONE_OFF [*2] |-> !tone_out) // [R14]
        else $error("tone active while silenced");
    clear_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
        iface_clear |-> !clk_chip_we && !nv_we && !nv_enable) // [R18]
        else $error("chip write during interface clear");
    loop_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && reg_sel == ksc_pkg::REG_LOOP ##1
        rd && reg_sel == ksc_pkg::REG_LOOP |=>
        data_out == $past(data_in, 2)) // [R6]
        else $error("loopback latch mismatch");
endmodule : ksc_interface
`default_nettype wire

// >>> testbench/ksc_chip_model.sv
`default_nettype none
// Clock chip and store seen from the device's chip-side pins.
module ksc_chip_model (
    input wire logic clk,
    input wire logic clk_en,
    input wire logic clk_we,
    input wire logic [3:0] clk_addr,
    input wire logic [3:0] clk_wdata,
    output logic [3:0] clk_rdata,
    input wire logic nv_en,
    input wire logic nv_we,
    input wire logic [10:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    output logic [7:0] nv_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cmem [16];
    logic [7:0] nmem [2048];
    logic [3:0] clast = 4'h0;
    logic [7:0] nlast = 8'h0;
    always @(posedge clk) begin
        if (clk_en && clk_we) cmem[clk_addr] <= clk_wdata;
        if (nv_en && nv_we) nmem[nv_addr] <= nv_wdata;
        if (clk_en) clast <= cmem[clk_addr];
        if (nv_en) nlast <= nmem[nv_addr];
    end
    // A disabled chip floats, so show the inverse rather than stale data.
    assign clk_rdata = clk_en ? cmem[clk_addr] : ~clast;
    assign nv_rdata = nv_en ? nmem[nv_addr] : ~nlast;
endmodule : ksc_chip_model
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] pa = 3'h6;
    logic [3:0] reg_sel = 4'h0;
    logic rd_strobe = 1'b0;
    logic wr_strobe = 1'b0;
    logic poll = 1'b0;
    logic iface_clear = 1'b0;
    logic pfw = 1'b1;
    logic p_stat = 1'b0;
    logic p_flag = 1'b0;
    logic batt_low = 1'b1;
    logic [15:0] data_in = 16'h0000;
    logic [15:0] data_out, data_oe_n, rdv, roe;
    logic stat_low, flag_low, tone_out, ce, cwe, ne, nwe, press = 1'b0;
    logic [7:0] key_rows = 8'h00;
    logic [3:0] key_column, ca, cwd, crd;
    logic [1:0] led;
    logic [4:0] rep;
    logic [10:0] na;
    logic [7:0] nwd, nrd;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int k;
    always #2.5 clk = ~clk;
    ksc_interface #(.LOCK_CYCLES(50)) ksc_interface_inst (
        .clk(clk), .rst_n(rst_n), .periph_addr(pa), .reg_sel(reg_sel),
        .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .poll(poll),
        .iface_clear(iface_clear), .power_fail_warn(pfw),
        .battery_low(batt_low), .printer_status(p_stat),
        .printer_flag(p_flag), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .select_code_status_low(stat_low),
        .select_code_flag_low(flag_low), .key_rows(key_rows),
        .shift_key(1'b0), .ctrl_key(1'b1), .key_column(key_column),
        .language_strap(4'hB), .led(led), .repeat_select(rep),
        .tone_out(tone_out), .clk_chip_enable(ce), .clk_chip_we(cwe),
        .clk_chip_addr(ca), .clk_chip_wdata(cwd), .clk_chip_rdata(crd),
        .nv_enable(ne), .nv_we(nwe), .nv_addr(na), .nv_wdata(nwd),
        .nv_rdata(nrd));
    ksc_chip_model ksc_chip_model_inst (
        .clk(clk), .clk_en(ce), .clk_we(cwe), .clk_addr(ca),
        .clk_wdata(cwd), .clk_rdata(crd), .nv_en(ne), .nv_we(nwe),
        .nv_addr(na), .nv_wdata(nwd), .nv_rdata(nrd));
    // One key, row 1 of column 5, pressed while press is high.
    always @(negedge clk) begin
        key_rows <= (press && key_column == 4'h5) ? 8'h02 : 8'h00;
    end
    task automatic report_and_stop();
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic rd(input logic [3:0] r);
        @(negedge clk);
        reg_sel = r;
        rd_strobe = 1'b1;
        @(negedge clk);
        rd_strobe = 1'b0;
        rdv = data_out;
        roe = data_oe_n;
    endtask : rd
    task automatic wr(input logic [3:0] r, input logic [15:0] d);
        @(negedge clk);
        reg_sel = r;
        data_in = d;
        wr_strobe = 1'b1;
        @(negedge clk);
        wr_strobe = 1'b0;
    endtask : wr
    initial begin
        repeat (4) @(negedge clk);
        `CHK(data_oe_n, 16'hFFFF)
        `CHK({tone_out, led}, 3'h0)
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        rd(4'h3);
        `CHK(rdv[7:0], ksc_pkg::ID_VALUE)
        `CHK(roe, 16'hFF00)
        pa = 3'h5;
        rd(4'h3);
        `CHK(roe, 16'hFFFF)
        pa = 3'h6;
        rd(4'h0);
        `CHK(roe, 16'hFFFF)
        wr(4'h1, 16'hFFFF);
        rd(4'h1);
        `CHK(rdv[11:0], 12'h0BA)
        `CHK(roe, 16'hF000)
        wr(4'hF, 16'hA55A);
        rd(4'hF);
        `CHK({roe, rdv}, 32'h0000A55A)
        wr(4'hA, 16'h007E);
        `CHK({led, rep}, 7'h5F)
        // One load sets clock address C and store address 123.
        wr(4'hC, 16'hFEDC);
        `CHK({ca, na}, 15'h6123)
        wr(4'h9, 16'h000A);
        wr(4'h9, 16'h0005);
        wr(4'hD, 16'h00C3);
        wr(4'hC, 16'hFEDC);
        rd(4'h9);
        `CHK(rdv[3:0], 4'hA)
        rd(4'h9);
        `CHK(rdv[3:0], 4'h5)
        rd(4'hD);
        `CHK(rdv[7:0], 8'hC3)
        iface_clear = 1'b1;
        #1;
        `CHK({ce, ne}, 2'b00)
        rd(4'h9);
        `CHK(roe, 16'hFFFF)
        iface_clear = 1'b0;
        p_stat = 1'b1;
        p_flag = 1'b1;
        repeat (2) @(negedge clk);
        `CHK({stat_low, flag_low}, 2'b00)
        p_stat = 1'b0;
        p_flag = 1'b0;
        repeat (2) @(negedge clk);
        `CHK({stat_low, flag_low}, 2'b11)
        press = 1'b1;
        k = 0;
        while (stat_low !== 1'b0 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        `CHK(stat_low, 1'b0)
        press = 1'b0;
        poll = 1'b1;
        #1;
        `CHK(flag_low, 1'b0)
        @(negedge clk);
        poll = 1'b0;
        rd(4'hA);
        `CHK(rdv[8:0], 9'h0A9)
        `CHK(roe, 16'h0000)
        repeat (2) @(negedge clk);
        `CHK(stat_low, 1'b1)
        rd(4'h1);
        `CHK(rdv[0], 1'b0)
        wr(4'hB, 16'h0001);
        k = 0;
        while (tone_out !== 1'b1 && k < 10000) begin
            @(negedge clk);
            k++;
        end
        `CHK(tone_out, 1'b1)
        wr(4'hB, 16'h00FF);
        repeat (3000) @(negedge clk);
        `CHK(tone_out, 1'b0)
        // A second power-up with a healthy battery clears the failure bit.
        rst_n = 1'b0;
        batt_low = 1'b0;
        @(negedge clk);
        `CHK({data_oe_n, tone_out}, 17'h1FFFE)
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        rd(4'h1);
        `CHK(rdv[3], 1'b0)
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
